// file: design/prd_pkg.sv
// constants shared by the page register and address decoder
// assumes one 250 MHz clock; all pins are synchronised before use
package prd_pkg;
    // bus and decoder widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 4;
    localparam int EPROM_N = 7;
    localparam int NSEL = 9;
    localparam int UP_W = 2;
    // select term indices beyond the eprom blocks
    localparam int SEL_SRAM = 7;
    localparam int SEL_PORT = 8;
    // address match patterns
    localparam int BLK_MSB = 15;
    localparam int BLK_LSB = 13;
    localparam int WIN_LSB = 11;
    localparam logic [4:0] SRAM_MATCH = 5'h1C;
    localparam logic [4:0] PORT_MATCH = 5'h1B;
    // page register offset within the io window and its reset value
    localparam logic [10:0] PAGE_SELECT_OFF = 11'h018;
    localparam logic [PAGE_W-1:0] PAGE_SELECT_RST = 4'h0;
    // packed configuration word, field positions
    localparam int CFG_W = 64;
    localparam int CFG_COMMON_LSB = 0;
    localparam int CFG_PAGE_LSB = 9;
    localparam int CFG_PBCS_LSB = 45;
    localparam int CFG_UPCS_LSB = 53;
    localparam int CFG_EXTM_LSB = 55;
    localparam int CFG_EXTV_LSB = 57;
    localparam int CFG_HLAT_BIT = 59;
    localparam logic [CFG_W-1:0] CFG_RST = 64'h0;
    localparam int PROG_IDX_W = 3;
    // strobe delay through the decoder
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STROBE_DLY_NS = 15;
    localparam int STROBE_DLY_CYC = (STROBE_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // synchroniser reset levels
    localparam logic [2:0] CTRL_SYNC_RST = 3'h7;
endpackage

// file: design/prd_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
// assumes the inputs are levels that change slowly against mclk_i
module prd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // pins in, synchronised out
    input wire logic [W-1:0] async_i,
    input wire logic unused_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
        end else begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
        end
    end

    assign sync_o = s2_ff;
endmodule

// file: design/prd_page_reg.sv
// four-bit page value with write strobe and read-back byte
// assumes the write pulse is already decoded and one cycle long
module prd_page_reg
    import prd_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // write side
    input wire logic wr_i,
    input wire logic [prd_pkg::PAGE_W-1:0] data_i,
    // read side
    output logic [prd_pkg::PAGE_W-1:0] page_o,
    output logic [prd_pkg::DATA_W-1:0] rd_data_o
);
    import prd_pkg::*;
    logic [PAGE_W-1:0] page_ff;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page_ff <= PAGE_SELECT_RST;
        end else if (wr_i) begin
            page_ff <= data_i;
        end
    end

    assign page_o = page_ff;
    // upper data lines read as zero
    assign rd_data_o = {{(DATA_W - PAGE_W){1'b0}}, page_ff};
endmodule

// file: design/prd_decoder.sv
// page register and address decoder behind an 8-bit non-multiplexed host bus
// assumes the host drives levels asynchronously; every pin is synchronised here
// How it works
// - four page bits, host readable and writable
// - page uses data lines 3..0 only
// - page sits at io window plus 18h
// - page bits extend decoder inputs
// - each select common or page specific
// - security freezes decoder and configuration
// - secured part refuses programmer read-back
// - eight-bit bus, read/write plus strobe
// - first port pins carry host data
// - second port pins: io or select
// - upper third port pins: input or select
// - pin0 outputs strobe delayed, same polarity
// - address captured by latch strobe
// - eprom blocks decode on address 15..13
// - sram select at e000 to e7ff
// - io window select at d800 to dfff
// - io window beats overlapped eprom block
// - read/write high reads, low writes
// - capture on falling latch strobe edge
// - selects inactive during and after reset
module prd_decoder
    import prd_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // host bus control and address
    input wire logic [prd_pkg::ADDR_W-1:0] addr_i,
    input wire logic rw_i,
    input wire logic data_strobe_low_i,
    input wire logic addr_latch_strobe_i,
    // first port: host data bus
    input wire logic [prd_pkg::DATA_W-1:0] first_port_pins_i,
    output logic [prd_pkg::DATA_W-1:0] first_port_pins_o,
    output logic [prd_pkg::DATA_W-1:0] first_port_pins_oe_n_o,
    // second port: io or chip select
    input wire logic [prd_pkg::DATA_W-1:0] second_port_pins_i,
    output logic [prd_pkg::DATA_W-1:0] second_port_pins_o,
    output logic [prd_pkg::DATA_W-1:0] second_port_pins_oe_n_o,
    input wire logic [prd_pkg::DATA_W-1:0] second_port_io_out_i,
    input wire logic [prd_pkg::DATA_W-1:0] second_port_io_dir_i,
    output logic [prd_pkg::DATA_W-1:0] second_port_io_in_o,
    // third port
    output logic third_port_pin0_o,
    input wire logic [prd_pkg::UP_W-1:0] third_port_upper_pins_i,
    output logic [prd_pkg::UP_W-1:0] third_port_upper_pins_o,
    output logic [prd_pkg::UP_W-1:0] third_port_upper_pins_oe_n_o,
    // internal selects, active low, and the page bits
    output logic [prd_pkg::EPROM_N-1:0] eprom_block_select_n_o,
    output logic sram_select_n_o,
    output logic port_window_select_n_o,
    output logic [prd_pkg::PAGE_W-1:0] page_bits_o,
    // configuration
    input wire logic [prd_pkg::NSEL-1:0] sel_common_cfg_i,
    input wire logic [prd_pkg::NSEL*prd_pkg::PAGE_W-1:0] sel_page_cfg_i,
    input wire logic [prd_pkg::DATA_W-1:0] second_port_cs_cfg_i,
    input wire logic [prd_pkg::UP_W-1:0] upper_pins_cs_cfg_i,
    input wire logic [prd_pkg::UP_W-1:0] ext_mask_cfg_i,
    input wire logic [prd_pkg::UP_W-1:0] ext_val_cfg_i,
    input wire logic high_address_latch_cfg_i,
    input wire logic security_lock_cfg_i,
    output logic security_locked_o,
    // programmer read-back
    input wire logic prog_rd_i,
    input wire logic [prd_pkg::PROG_IDX_W-1:0] prog_idx_i,
    output logic prog_valid_o,
    output logic prog_refused_o,
    output logic [prd_pkg::DATA_W-1:0] prog_data_o
);
    import prd_pkg::*;
    localparam int DSYNC_W = ADDR_W + 2 * DATA_W + UP_W + CFG_W - 4 + 1;

    // synchronised pins
    logic [2:0] ctrl_s;
    logic [DSYNC_W-1:0] data_raw;
    logic [DSYNC_W-1:0] data_s;
    logic ds_s;
    logic ale_s;
    logic rw_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] pa_s;
    logic [DATA_W-1:0] pb_s;
    logic [UP_W-1:0] up_s;
    logic [CFG_W-1:0] cfg_in;
    logic sec_s;

    // registered state
    logic ds_d_ff;
    logic ale_d_ff;
    logic [ADDR_W-1:0] addr_lat_ff;
    logic [UP_W-1:0] up_lat_ff;
    logic fresh_ff;
    logic lat_ok_ff;
    logic sec_ff;
    logic [CFG_W-1:0] cfg_ff;
    logic [STROBE_DLY_CYC-1:0] dly_ff;
    logic pin0_ff;
    logic [NSEL-1:0] sel_n_ff;
    logic [DATA_W-1:0] pa_out_ff;
    logic [DATA_W-1:0] pa_oe_n_ff;
    logic [DATA_W-1:0] pb_out_ff;
    logic [DATA_W-1:0] pb_oe_n_ff;
    logic [DATA_W-1:0] pb_in_ff;
    logic [UP_W-1:0] up_out_ff;
    logic [UP_W-1:0] up_oe_n_ff;
    logic [PAGE_W-1:0] page_bits_ff;
    logic prog_valid_ff;
    logic prog_refused_ff;
    logic [DATA_W-1:0] prog_data_ff;

    // decode wires
    logic ds_trail;
    logic ale_fall;
    logic [UP_W-1:0] up_used;
    logic [UP_W-1:0] ext_care;
    logic ext_ok;
    logic [NSEL-1:0] hit;
    logic [NSEL-1:0] page_ok;
    logic [NSEL-1:0] sel_term;
    logic io_window_select;
    logic page_addr;
    logic page_wr;
    logic page_rd;
    logic [PAGE_W-1:0] page_bits;
    logic [DATA_W-1:0] page_rd_data;
    logic [DATA_W-1:0] pb_cs;
    logic [UP_W-1:0] up_cs;
    logic [DATA_W-1:0] prog_byte;

    assign cfg_in = {4'h0, high_address_latch_cfg_i, ext_val_cfg_i, ext_mask_cfg_i,
                     upper_pins_cs_cfg_i, second_port_cs_cfg_i, sel_page_cfg_i,
                     sel_common_cfg_i};
    assign data_raw = {security_lock_cfg_i, cfg_in[CFG_W-5:0], third_port_upper_pins_i,
                       second_port_pins_i, first_port_pins_i, addr_i};

    prd_sync #(.W(3), .RST_VAL(CTRL_SYNC_RST)) u_ctrl_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i({rw_i, addr_latch_strobe_i, data_strobe_low_i}),
        .unused_i(1'b0),
        .sync_o(ctrl_s)
    );

    prd_sync #(.W(DSYNC_W), .RST_VAL('0)) u_data_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i(data_raw),
        .unused_i(1'b0),
        .sync_o(data_s)
    );

    assign ds_s = ctrl_s[0];
    assign ale_s = ctrl_s[1];
    assign rw_s = ctrl_s[2];
    assign addr_s = data_s[ADDR_W-1:0];
    // first port is the data bus
    assign pa_s = data_s[ADDR_W +: DATA_W];
    assign pb_s = data_s[ADDR_W+DATA_W +: DATA_W];
    assign up_s = data_s[ADDR_W+2*DATA_W +: UP_W];
    assign sec_s = data_s[DSYNC_W-1];

    assign ds_trail = ds_s & ~ds_d_ff;
    // falling edge of the latch strobe
    assign ale_fall = ale_d_ff & ~ale_s;

    // upper pins as decoder inputs, latched or transparent
    assign up_used = cfg_ff[CFG_HLAT_BIT] ? up_lat_ff : up_s;
    assign ext_care = cfg_ff[CFG_EXTM_LSB +: UP_W] & ~cfg_ff[CFG_UPCS_LSB +: UP_W];
    assign ext_ok = ((up_used ^ cfg_ff[CFG_EXTV_LSB +: UP_W]) & ext_care) == '0;

    genvar k;
    generate
        for (k = 0; k < EPROM_N; k++) begin : g_eprom
            if (k == EPROM_N - 1) begin : g_last
                assign hit[k] = (addr_lat_ff[BLK_MSB:BLK_LSB] == 3'(k)) & ~hit[SEL_PORT];
            end else begin : g_blk
                assign hit[k] = addr_lat_ff[BLK_MSB:BLK_LSB] == 3'(k);
            end
        end
    endgenerate
    assign hit[SEL_SRAM] = addr_lat_ff[BLK_MSB:WIN_LSB] == SRAM_MATCH;
    assign hit[SEL_PORT] = addr_lat_ff[BLK_MSB:WIN_LSB] == PORT_MATCH;

    generate
        for (k = 0; k < NSEL; k++) begin : g_page
            assign page_ok[k] = cfg_ff[CFG_COMMON_LSB + k] |
                                (page_bits == cfg_ff[CFG_PAGE_LSB + k*PAGE_W +: PAGE_W]);
            assign sel_term[k] = hit[k] & page_ok[k] & ext_ok & lat_ok_ff;
        end
    endgenerate

    assign io_window_select = sel_term[SEL_PORT];
    assign page_addr = io_window_select & fresh_ff &
                       (addr_lat_ff[WIN_LSB-1:0] == PAGE_SELECT_OFF);
    assign page_wr = ds_trail & ~rw_s & page_addr;
    assign page_rd = ~ds_s & rw_s & page_addr;

    prd_page_reg u_page (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .wr_i(page_wr),
        .data_i(pa_s[PAGE_W-1:0]),
        .page_o(page_bits),
        .rd_data_o(page_rd_data)
    );

    // chip select terms offered to the port pins
    assign pb_cs = {~sel_term[SEL_SRAM], ~sel_term[EPROM_N-1:0]};
    assign up_cs = {~sel_term[SEL_SRAM], ~sel_term[SEL_PORT]};
    assign prog_byte = cfg_ff[8 * prog_idx_i +: DATA_W];

    // edge history and address capture
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ds_d_ff <= 1'b1;
            ale_d_ff <= 1'b1;
            addr_lat_ff <= '0;
            up_lat_ff <= '0;
            fresh_ff <= 1'b0;
            lat_ok_ff <= 1'b0;
        end else begin
            ds_d_ff <= ds_s;
            ale_d_ff <= ale_s;
            if (ale_fall) begin
                addr_lat_ff <= addr_s;
                up_lat_ff <= up_s;
                lat_ok_ff <= 1'b1;
            end
            if (ale_fall) begin
                fresh_ff <= 1'b1;
            end else if (ds_trail) begin
                fresh_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_ff <= 1'b0;
            cfg_ff <= CFG_RST;
        end else begin
            sec_ff <= sec_ff | sec_s;
            if (!sec_ff) begin
                cfg_ff <= {4'h0, sec_s ? cfg_ff[CFG_W-5:0] : data_s[DSYNC_W-2:ADDR_W+2*DATA_W+UP_W]};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dly_ff <= '1;
            pin0_ff <= 1'b1;
        end else begin
            dly_ff <= {dly_ff[STROBE_DLY_CYC-2:0], ds_s};
            pin0_ff <= dly_ff[STROBE_DLY_CYC-1];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_n_ff <= '1;
            page_bits_ff <= PAGE_SELECT_RST;
        end else begin
            sel_n_ff <= ~sel_term;
            page_bits_ff <= page_bits;
        end
    end

    // host data bus drive for page read-back
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pa_out_ff <= '0;
            pa_oe_n_ff <= '1;
        end else begin
            pa_out_ff <= page_rd_data;
            pa_oe_n_ff <= {DATA_W{~page_rd}};
        end
    end

    // second port per pin io or select
    generate
        for (k = 0; k < DATA_W; k++) begin : g_pb
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pb_out_ff[k] <= 1'b1;
                    pb_oe_n_ff[k] <= 1'b1;
                end else if (cfg_ff[CFG_PBCS_LSB + k]) begin
                    pb_out_ff[k] <= pb_cs[k];
                    pb_oe_n_ff[k] <= 1'b0;
                end else begin
                    pb_out_ff[k] <= second_port_io_out_i[k];
                    pb_oe_n_ff[k] <= ~second_port_io_dir_i[k];
                end
            end
        end
        for (k = 0; k < UP_W; k++) begin : g_up
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    up_out_ff[k] <= 1'b1;
                    up_oe_n_ff[k] <= 1'b1;
                end else begin
                    up_out_ff[k] <= cfg_ff[CFG_UPCS_LSB + k] ? up_cs[k] : 1'b1;
                    up_oe_n_ff[k] <= ~cfg_ff[CFG_UPCS_LSB + k];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pb_in_ff <= '0;
        end else begin
            pb_in_ff <= pb_s;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_valid_ff <= 1'b0;
            prog_refused_ff <= 1'b0;
            prog_data_ff <= '0;
        end else begin
            prog_valid_ff <= prog_rd_i & ~sec_ff;
            prog_refused_ff <= prog_rd_i & sec_ff;
            prog_data_ff <= (prog_rd_i & ~sec_ff) ? prog_byte : '0;
        end
    end

    assign first_port_pins_o = pa_out_ff;
    assign first_port_pins_oe_n_o = pa_oe_n_ff;
    assign second_port_pins_o = pb_out_ff;
    assign second_port_pins_oe_n_o = pb_oe_n_ff;
    assign second_port_io_in_o = pb_in_ff;
    assign third_port_pin0_o = pin0_ff;
    assign third_port_upper_pins_o = up_out_ff;
    assign third_port_upper_pins_oe_n_o = up_oe_n_ff;
    assign eprom_block_select_n_o = sel_n_ff[EPROM_N-1:0];
    assign sram_select_n_o = sel_n_ff[SEL_SRAM];
    assign port_window_select_n_o = sel_n_ff[SEL_PORT];
    assign page_bits_o = page_bits_ff;
    assign security_locked_o = sec_ff;
    assign prog_valid_o = prog_valid_ff;
    assign prog_refused_o = prog_refused_ff;
    assign prog_data_o = prog_data_ff;
endmodule

// file: verification/prd_decoder_properties.sv
// assertions on the ports of prd_decoder
// bound from the bench top; one clock, async active-low reset
module prd_chk
    import prd_pkg::*;
(
    // clock, reset and host bus
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [prd_pkg::ADDR_W-1:0] addr_i,
    input wire logic rw_i,
    input wire logic data_strobe_low_i,
    // decoder outputs
    input wire logic [prd_pkg::DATA_W-1:0] first_port_pins_o,
    input wire logic [prd_pkg::DATA_W-1:0] first_port_pins_oe_n_o,
    input wire logic third_port_pin0_o,
    input wire logic [prd_pkg::EPROM_N-1:0] eprom_block_select_n_o,
    input wire logic sram_select_n_o,
    input wire logic port_window_select_n_o,
    input wire logic [prd_pkg::PAGE_W-1:0] page_bits_o,
    // lock and programmer
    input wire logic security_lock_cfg_i,
    input wire logic security_locked_o,
    input wire logic prog_rd_i,
    input wire logic prog_valid_o,
    input wire logic prog_refused_o,
    input wire logic [prd_pkg::DATA_W-1:0] prog_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire [8:0] sel_n = {port_window_select_n_o, sram_select_n_o, eprom_block_select_n_o};
    wire page_hit = addr_i[15:11] == PORT_MATCH && addr_i[10:0] == PAGE_SELECT_OFF;
    sequence s_ds_fall;
        $fell(data_strobe_low_i);
    endsequence
    // address is latched and decoded a few cycles after the delayed strobe falls
    sequence s_latched;
        $fell(third_port_pin0_o) ##6 !data_strobe_low_i;
    endsequence
    chk_reset_idle: assert property (
        $rose(rst_n_i) |-> &sel_n && page_bits_o == PAGE_SELECT_RST) else $error("not idle");
    chk_pin0_delay: assert property (
        s_ds_fall |-> ##[3:9] $fell(third_port_pin0_o)) else $error("pin0 not delayed strobe");
    chk_eprom_onehot: assert property (
        $onehot0(~eprom_block_select_n_o)) else $error("two blocks selected");
    chk_window_wins: assert property (
        !port_window_select_n_o |-> eprom_block_select_n_o[6]) else $error("block 6 in window");
    chk_sram_range: assert property (
        s_latched |-> sram_select_n_o || addr_i[15:11] == SRAM_MATCH) else $error("sram range");
    chk_window_range: assert property (
        s_latched |-> port_window_select_n_o || addr_i[15:11] == PORT_MATCH) else $error("window");
    chk_block_range: assert property (
        s_latched |-> &eprom_block_select_n_o || !eprom_block_select_n_o[addr_i[15:13]])
        else $error("block range");
    chk_read_page: assert property (
        !first_port_pins_oe_n_o[0] && page_hit |-> first_port_pins_o == {4'h0, page_bits_o})
        else $error("page read data");
    chk_page_write: assert property (
        $changed(page_bits_o) |-> !rw_i && page_hit) else $error("page changed without write");
    chk_prog_answer: assert property (
        prog_rd_i |=> prog_valid_o != prog_refused_o) else $error("no programmer answer");
    chk_refuse_zero: assert property (
        prog_refused_o |-> prog_data_o == 8'h00 && security_locked_o) else $error("refusal");
    chk_lock_sticky: assert property (
        security_locked_o |=> security_locked_o) else $error("lock dropped");
    chk_lock_set: assert property (
        security_lock_cfg_i |-> ##[1:5] security_locked_o) else $error("lock not set");
endmodule

// file: verification/prd_host_model.sv
// host controller model: 8-bit non-multiplexed bus, read/write level and data strobe
// the bench calls xfer and resolves the shared data line
module prd_host_model
    import prd_pkg::*;
#(
    parameter int OBS_W = 27
) (
    // clock
    input wire logic mclk_i,
    // bus pins
    output logic [prd_pkg::ADDR_W-1:0] addr_o,
    output logic rw_o,
    output logic ds_n_o,
    output logic [prd_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [prd_pkg::DATA_W-1:0] data_i,
    // one snapshot per transfer
    input wire logic [OBS_W-1:0] obs_i,
    output logic done_o,
    output logic [prd_pkg::DATA_W-1:0] rdata_o,
    output logic [OBS_W-1:0] obs_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_o = '0;
        rw_o = 1'b1;
        ds_n_o = 1'b1;
        data_o = '0;
        data_oe_o = 1'b0;
        done_o = 1'b0;
        rdata_o = '0;
        obs_o = '0;
    end
    // rw high reads, low writes; strobe held long enough to latch
    task automatic xfer(input logic [ADDR_W-1:0] a, input logic rd, input logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rw_o <= rd;
        data_o <= d;
        data_oe_o <= !rd;
        @(posedge mclk_i);
        ds_n_o <= 1'b0;
        repeat (18) @(posedge mclk_i);
        rdata_o <= data_i;
        obs_o <= obs_i;
        ds_n_o <= 1'b1;
        done_o <= 1'b1;
        @(posedge mclk_i);
        done_o <= 1'b0;
        data_oe_o <= 1'b0;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule

// file: verification/tb_top.sv
// self-checking bench for the page register and address decoder
// host model drives the bus; expected results are queued and checked as they appear
`define CMP(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module tb_top
    import prd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] h_addr;
    logic h_rw, h_ds, h_oe, h_done;
    logic [7:0] h_d, h_rd, first_port_pins_o, first_port_pins_oe_n_o, second_port_pins_o;
    logic [7:0] second_port_pins_oe_n_o, second_port_io_in_o, prog_data_o, pb_ext;
    logic [7:0] second_port_io_out_i, second_port_io_dir_i, second_port_cs_cfg_i;
    logic [1:0] third_port_upper_pins_o, third_port_upper_pins_oe_n_o, up_ext;
    logic [1:0] upper_pins_cs_cfg_i, ext_mask_cfg_i, ext_val_cfg_i;
    logic [6:0] eprom_block_select_n_o;
    logic sram_select_n_o, port_window_select_n_o, third_port_pin0_o, security_locked_o;
    logic prog_valid_o, prog_refused_o, prog_rd_i, high_address_latch_cfg_i, security_lock_cfg_i;
    logic [3:0] page_bits_o;
    logic [8:0] sel_common_cfg_i;
    logic [35:0] sel_page_cfg_i;
    logic [2:0] prog_idx_i;
    logic [26:0] h_obs;
    logic [69:0] q_bus[$];
    logic [9:0] q_prog[$];
    int err_count = 0;
    int n_tests = 0;
    logic [15:0] adr[14] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h5A5A, 16'h8000, 16'hBFFF, 16'hC000,
        16'hD7FF, 16'hD800, 16'hDFFF, 16'hE000, 16'hE7FF, 16'hE800, 16'hFFFF};
    wire [8:0] sel_n = {port_window_select_n_o, sram_select_n_o, eprom_block_select_n_o};
    // a released data line shows the inverse of the host's last value
    wire [7:0] fp_bus = h_oe ? h_d : (first_port_pins_o & ~first_port_pins_oe_n_o)
        | (~h_d & first_port_pins_oe_n_o);
    wire [7:0] pb_bus = (second_port_pins_o & ~second_port_pins_oe_n_o)
        | (pb_ext & second_port_pins_oe_n_o);
    wire [1:0] up_bus = (third_port_upper_pins_o & ~third_port_upper_pins_oe_n_o)
        | (up_ext & third_port_upper_pins_oe_n_o);
    wire [63:0] cfg_word = {4'h0, high_address_latch_cfg_i, ext_val_cfg_i, ext_mask_cfg_i,
        upper_pins_cs_cfg_i, second_port_cs_cfg_i, sel_page_cfg_i, sel_common_cfg_i};

    prd_host_model #(.OBS_W(27)) u_host (.mclk_i(mclk_i), .addr_o(h_addr), .rw_o(h_rw),
        .ds_n_o(h_ds), .data_o(h_d), .data_oe_o(h_oe), .data_i(fp_bus),
        .obs_i({second_port_io_in_o, up_bus, pb_bus, sel_n}), .done_o(h_done),
        .rdata_o(h_rd), .obs_o(h_obs));
    prd_decoder u_dut (.addr_i(h_addr), .rw_i(h_rw), .data_strobe_low_i(h_ds),
        .addr_latch_strobe_i(third_port_pin0_o), .first_port_pins_i(fp_bus),
        .second_port_pins_i(pb_bus), .third_port_upper_pins_i(up_bus), .*);

    always #2 mclk_i = ~mclk_i;

    function automatic logic [26:0] exp_obs(input logic [15:0] a, input logic [8:0] en);
        logic [8:0] s;
        logic [7:0] pb;
        logic [1:0] up;
        s = '1;
        up = up_ext;
        if (a[15:11] == PORT_MATCH) s[SEL_PORT] = 1'b0;
        else if (a[15:13] != 3'h7) s[a[15:13]] = 1'b0;
        if (a[15:11] == SRAM_MATCH) s[SEL_SRAM] = 1'b0;
        if (((up_ext ^ ext_val_cfg_i) & ext_mask_cfg_i & ~upper_pins_cs_cfg_i) != 2'h0) en = '0;
        s = s | ~en;
        if (upper_pins_cs_cfg_i[0]) up[0] = s[SEL_PORT];
        if (upper_pins_cs_cfg_i[1]) up[1] = s[SEL_SRAM];
        for (int k = 0; k < 8; k++)
            pb[k] = second_port_cs_cfg_i[k] ? s[k] : second_port_io_dir_i[k]
                ? second_port_io_out_i[k] : pb_ext[k];
        return {pb, up, pb, s};
    endfunction

    task automatic xfer(input logic [15:0] a, input logic rd, input logic [7:0] d,
        input logic [8:0] en, input logic [7:0] rm, input logic [7:0] re);
        q_bus.push_back({rm, 27'h7FFFFFF, re, exp_obs(a, en)});
        u_host.xfer(a, rd, d);
    endtask

    task automatic prog(input logic [2:0] i, input logic [9:0] e);
        q_prog.push_back(e);
        @(posedge mclk_i);
        prog_rd_i <= 1'b1;
        prog_idx_i <= i;
    endtask

    task automatic close_out();
        if (q_bus.size() != 0 || q_prog.size() != 0) err_count++;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge mclk_i) begin
        logic [69:0] nb;
        logic [9:0] np;
        if (h_done) begin
            nb = q_bus.size() ? q_bus.pop_front() : 'x;
            `CMP({h_rd, h_obs} & nb[69:35], nb[34:0])
        end
        if (prog_valid_o || prog_refused_o) begin
            np = q_prog.size() ? q_prog.pop_front() : 'x;
            `CMP({prog_valid_o, prog_refused_o, prog_data_o}, np)
        end
    end

    initial begin
        logic [3:0] v;
        void'($urandom(32'h3e5cf7a9));
        sel_common_cfg_i = 9'h1FF;
        sel_page_cfg_i = '0;
        second_port_cs_cfg_i = 8'h00;
        upper_pins_cs_cfg_i = 2'h0;
        ext_mask_cfg_i = 2'h0;
        ext_val_cfg_i = 2'h0;
        high_address_latch_cfg_i = 1'b1;
        security_lock_cfg_i = 1'b0;
        prog_rd_i = 1'b0;
        prog_idx_i = 3'h0;
        up_ext = 2'h1;
        {second_port_io_out_i, second_port_io_dir_i, pb_ext} = 24'($urandom);
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        foreach (adr[i]) xfer(adr[i], 1'b1, 8'h00, 9'h1FF, 8'h00, 8'h00);
        repeat (8) xfer(16'($urandom), 1'b1, 8'h00, 9'h1FF, 8'h00, 8'h00);
        xfer(16'hD818, 1'b1, 8'h00, 9'h1FF, 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
            xfer(16'hD818, 1'b0, {4'($urandom), v}, 9'h1FF, 8'h00, 8'h00);
            xfer(16'hD819, 1'b0, 8'h00, 9'h1FF, 8'h00, 8'h00);
            xfer(16'hD818, 1'b1, 8'h00, 9'h1FF, 8'hFF, {4'h0, v});
        end
        @(posedge mclk_i);
        sel_common_cfg_i <= 9'h13F;
        sel_page_cfg_i <= {4'h0, 4'h3, 4'h3, 24'h0};
        repeat (4) @(posedge mclk_i);
        for (int p = 5; p >= 3; p -= 2) begin
            xfer(16'hD818, 1'b0, 8'(p), 9'h1FF, 8'h00, 8'h00);
            xfer(16'hC000, 1'b1, 8'h00, (p == 3) ? 9'h1FF : 9'h13F, 8'h00, 8'h00);
            xfer(16'hE000, 1'b1, 8'h00, (p == 3) ? 9'h1FF : 9'h13F, 8'h00, 8'h00);
        end
        @(posedge mclk_i);
        second_port_cs_cfg_i <= 8'hC1;
        upper_pins_cs_cfg_i <= 2'h1;
        ext_mask_cfg_i <= 2'h2;
        ext_val_cfg_i <= 2'h2;
        up_ext <= 2'h0;
        repeat (4) @(posedge mclk_i);
        xfer(16'h0000, 1'b1, 8'h00, 9'h1FF, 8'h00, 8'h00);
        up_ext <= 2'h2;
        high_address_latch_cfg_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        for (int i = 0; i < 12; i += 2) xfer(adr[i], 1'b1, 8'h00, 9'h1FF, 8'h00, 8'h00);
        for (int i = 0; i < 8; i++) prog(3'(i), {2'b10, cfg_word[8*i+:8]});
        @(posedge mclk_i);
        prog_rd_i <= 1'b0;
        security_lock_cfg_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        sel_common_cfg_i <= 9'h000;
        security_lock_cfg_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        xfer(16'h0000, 1'b1, 8'h00, 9'h1FF, 8'h00, 8'h00);
        for (int i = 0; i < 8; i++) prog(3'(i), 10'h100);
        @(posedge mclk_i);
        prog_rd_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        close_out();
    end

    initial begin
        repeat (6000) @(posedge mclk_i);
        err_count++;
        close_out();
    end
endmodule

bind prd_decoder prd_chk u_chk (.*);
